// ### nfpi_pkg.sv
package nfpi_pkg;
  // --------------------------------------------------------------
  // widths
  // --------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 10;

  // --------------------------------------------------------------
  // timing, 200 MHz clock
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int STROBE_LOW_NS = 25;
  localparam int STROBE_HIGH_NS = 25;
  localparam int RD_CYCLE_NS = 50;
  localparam int RD_VALID_NS = 35;
  localparam int STROBE_LOW_CYC =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC =
    (RD_CYCLE_NS - STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_SAMPLE_CYC =
    (RD_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STROBE_LOW_CNT = 8'(STROBE_LOW_CYC);
  localparam logic [7:0] STROBE_HIGH_CNT = 8'(STROBE_HIGH_CYC);
  localparam logic [7:0] RD_SAMPLE_CNT = 8'(RD_SAMPLE_CYC);
  // clocks allowed for the device to pull ready/busy low
  localparam logic [3:0] BUSY_WAIT_CNT = 4'hf;

  // --------------------------------------------------------------
  // commands
  // --------------------------------------------------------------
  localparam logic [7:0] CMD_READ_LO = 8'h00;
  localparam logic [7:0] CMD_READ_HI = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE = 8'h50;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;

  // --------------------------------------------------------------
  // host operations
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    NFPI_OP_READ,
    NFPI_OP_PROGRAM,
    NFPI_OP_ERASE,
    NFPI_OP_STATUS,
    NFPI_OP_RESET
  } nfpi_op_e;

  typedef enum logic [1:0] {
    NFPI_CYC_CMD,
    NFPI_CYC_ADDR,
    NFPI_CYC_WDATA,
    NFPI_CYC_RDATA
  } nfpi_cyc_e;
endpackage

// ### nfpi_cyc_if.sv
`timescale 1ns/1ps
interface nfpi_cyc_if;
  logic start;
  nfpi_pkg::nfpi_cyc_e kind;
  logic [nfpi_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [nfpi_pkg::DATA_W-1:0] rdata;

  modport seq (output start, output kind, output wdata,
               input done, input rdata);
  modport pin (input start, input kind, input wdata,
               output done, output rdata);
endinterface

// ### nfpi_bus_cycle.sv
`timescale 1ns/1ps
// one strobe cycle on the pins; strobes and bus drive come from flops
module nfpi_bus_cycle (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  nfpi_cyc_if.pin cyc,
  input wire logic [nfpi_pkg::DATA_W-1:0] io_in,
  output logic [nfpi_pkg::DATA_W-1:0] io_out,
  output logic io_oe,
  output logic io_oe_hi,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic output_strobe_n
);
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_HIGH} nfpi_bc_e;
  nfpi_bc_e state;
  logic [7:0] cnt;
  logic is_read;

  // --------------------------------------------------------------
  // strobe sequencing
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      is_read <= 1'b0;
      io_out <= '0;
      io_oe <= 1'b0;
      io_oe_hi <= 1'b0;
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else if (clk_en) begin
      cyc.done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cyc.start) begin
            is_read <= (cyc.kind == nfpi_pkg::NFPI_CYC_RDATA);
            cmd_latch <= (cyc.kind == nfpi_pkg::NFPI_CYC_CMD); // RQ4
            addr_latch <= (cyc.kind == nfpi_pkg::NFPI_CYC_ADDR); // RQ5
            // commands and addresses use the low byte only
            io_out <= (cyc.kind == nfpi_pkg::NFPI_CYC_WDATA) ? cyc.wdata
              : {{(nfpi_pkg::DATA_W-nfpi_pkg::BYTE_W){1'b0}},
                 cyc.wdata[nfpi_pkg::BYTE_W-1:0]}; // RQ3
            io_oe <= (cyc.kind != nfpi_pkg::NFPI_CYC_RDATA); // RQ1
            io_oe_hi <= (cyc.kind == nfpi_pkg::NFPI_CYC_WDATA); // RQ3
            if (cyc.kind == nfpi_pkg::NFPI_CYC_RDATA) begin
              output_strobe_n <= 1'b0; // RQ8
            end else begin
              write_strobe_n <= 1'b0;
            end
            cnt <= 8'h01;
            state <= S_LOW;
          end
        end
        S_LOW: begin
          cnt <= cnt + 8'h01;
          if (is_read && cnt == nfpi_pkg::RD_SAMPLE_CNT) begin
            cyc.rdata <= io_in; // RQ8
          end
          if (cnt >= nfpi_pkg::STROBE_LOW_CNT &&
              (!is_read || cnt >= nfpi_pkg::RD_SAMPLE_CNT)) begin
            // rising write edge latches the driven bus
            write_strobe_n <= 1'b1; // RQ6
            output_strobe_n <= 1'b1;
            cnt <= 8'h01;
            state <= S_HIGH;
          end
        end
        S_HIGH: begin
          cnt <= cnt + 8'h01;
          // bus stays driven through the hold after the rising edge
          if (cnt >= nfpi_pkg::STROBE_HIGH_CNT) begin // RQ15
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            io_oe <= 1'b0;
            io_oe_hi <= 1'b0;
            cyc.done <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ### nfpi_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: shared I/O carries command, address, write data in; read data out.
// RQ2: device floats I/O when deselected or outputs disabled.
// RQ3: x16 upper lines carry data only; commands, addresses use low byte.
// RQ4: command latched on write-strobe rise with command latch high.
// RQ5: address latched on write-strobe rise with address latch high.
// RQ6: all host writes sampled on write-strobe rising edge.
// RQ7: device ignores deselect while busy programming or erasing.
// RQ8: each output strobe fall yields next word and bumps column.
// RQ9: write protect low blocks program and erase.
// RQ10: ready/busy low during program, erase, random read.
// RQ11: ready/busy is open drain, unaffected by select.
// RQ12: spare select low includes spare columns; high skips them.
// RQ13: page program takes typically 200 us, busy meanwhile.
// RQ14: block erase takes typically 2 ms, busy meanwhile.
// RQ15: serial read at 50 ns per word; host takes 15 clocks (75 ns) per read word.
// RQ16: device sequences program and erase pulses itself.
// RQ17: read, program: column, low row, high row; erase: two rows.
// RQ18: device returns start pointer to first half after second half.
// RQ19: host waits for ready before new read, program or erase.
module nfpi_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire nfpi_pkg::nfpi_op_e req_op,
  input wire logic [7:0] req_column,
  input wire logic [15:0] req_row,
  input wire logic [nfpi_pkg::CNT_W-1:0] req_words,
  input wire logic req_upper_half,
  input wire logic req_include_spare,
  input wire logic req_write_enable,
  output logic req_ready,
  input wire logic [nfpi_pkg::DATA_W-1:0] wr_data,
  output logic wr_take,
  output logic [nfpi_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic op_done,
  input wire logic [nfpi_pkg::DATA_W-1:0] io_in,
  output logic [nfpi_pkg::DATA_W-1:0] io_out,
  output logic io_oe,
  output logic io_oe_hi,
  output logic chip_select_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic write_protect_n,
  output logic spare_select_n,
  input wire logic ready_busy_n
);
  // --------------------------------------------------------------
  // sequencer state
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    H_IDLE, H_CMD, H_ADDR, H_WDATA, H_CMD2, H_WAIT_BUSY,
    H_WAIT_READY, H_RDATA, H_END
  } nfpi_hs_e;

  nfpi_cyc_if cyc ();
  nfpi_hs_e state;
  nfpi_pkg::nfpi_op_e op;
  logic [1:0] addr_idx;
  logic [nfpi_pkg::CNT_W-1:0] words;
  logic [7:0] column;
  logic [15:0] row;
  logic busy_q;
  logic pending;
  logic [3:0] busy_wait;

  function automatic logic [7:0] first_cmd(input nfpi_pkg::nfpi_op_e o,
                                           input logic hi);
    case (o)
      nfpi_pkg::NFPI_OP_READ:
        first_cmd = hi ? nfpi_pkg::CMD_READ_HI : nfpi_pkg::CMD_READ_LO;
      nfpi_pkg::NFPI_OP_PROGRAM: first_cmd = nfpi_pkg::CMD_PROG_SETUP;
      nfpi_pkg::NFPI_OP_ERASE: first_cmd = nfpi_pkg::CMD_ERASE_SETUP;
      nfpi_pkg::NFPI_OP_STATUS: first_cmd = nfpi_pkg::CMD_STATUS;
      default: first_cmd = nfpi_pkg::CMD_RESET;
    endcase
  endfunction

  // number of address cycles: erase has only the two row cycles
  function automatic logic [1:0] addr_cycles(input nfpi_pkg::nfpi_op_e o);
    case (o)
      nfpi_pkg::NFPI_OP_READ, nfpi_pkg::NFPI_OP_PROGRAM:
        addr_cycles = 2'h3; // RQ17
      nfpi_pkg::NFPI_OP_ERASE: addr_cycles = 2'h2; // RQ17
      default: addr_cycles = 2'h0;
    endcase
  endfunction

  // --------------------------------------------------------------
  // pin cycle engine
  // --------------------------------------------------------------
  nfpi_bus_cycle u_cycle (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .cyc(cyc.pin),
    .io_in(io_in),
    .io_out(io_out),
    .io_oe(io_oe),
    .io_oe_hi(io_oe_hi),
    .cmd_latch(cmd_latch),
    .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n)
  );

  // ready/busy is a pin from outside; registered once before use
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else if (clk_en) begin
      busy_q <= !ready_busy_n; // RQ10
    end
  end

  // --------------------------------------------------------------
  // operation sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= H_IDLE;
      op <= nfpi_pkg::NFPI_OP_RESET;
      addr_idx <= 2'h0;
      words <= '0;
      column <= 8'h00;
      row <= 16'h0000;
      pending <= 1'b0;
      busy_wait <= 4'h0;
      req_ready <= 1'b0;
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      op_done <= 1'b0;
      chip_select_n <= 1'b1;
      write_protect_n <= 1'b0;
      spare_select_n <= 1'b1;
      cyc.start <= 1'b0;
      cyc.kind <= nfpi_pkg::NFPI_CYC_CMD;
      cyc.wdata <= '0;
    end else if (clk_en) begin
      cyc.start <= 1'b0;
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      op_done <= 1'b0;
      case (state)
        H_IDLE: begin
          chip_select_n <= 1'b1;
          // new array work only once the device reports ready
          req_ready <= !busy_q; // RQ19
          if (req_valid && req_ready && !busy_q) begin // RQ19
            req_ready <= 1'b0;
            op <= req_op;
            column <= req_column;
            row <= req_row;
            words <= req_words;
            // protect stays low except while a write was asked for
            write_protect_n <= req_write_enable; // RQ9
            spare_select_n <= !req_include_spare; // RQ12
            chip_select_n <= 1'b0;
            cyc.kind <= nfpi_pkg::NFPI_CYC_CMD;
            cyc.wdata <= {8'h00, first_cmd(req_op, req_upper_half)}; // RQ4
            cyc.start <= 1'b1;
            addr_idx <= 2'h0;
            pending <= 1'b1;
            state <= H_CMD;
          end
        end
        H_CMD: begin
          if (cyc.done) begin
            if (addr_cycles(op) != 2'h0) begin
              cyc.kind <= nfpi_pkg::NFPI_CYC_ADDR; // RQ5
              // erase skips the column cycle
              cyc.wdata <= (op == nfpi_pkg::NFPI_OP_ERASE)
                ? {8'h00, row[7:0]} : {8'h00, column}; // RQ17
              addr_idx <= (op == nfpi_pkg::NFPI_OP_ERASE) ? 2'h2 : 2'h1;
              cyc.start <= 1'b1;
              state <= H_ADDR;
            end else if (op == nfpi_pkg::NFPI_OP_STATUS) begin
              words <= 10'h001;
              state <= H_RDATA;
            end else begin
              busy_wait <= 4'h0;
              state <= H_WAIT_BUSY;
            end
          end
        end
        H_ADDR: begin
          if (cyc.done) begin
            if (addr_idx != 2'h3) begin
              cyc.kind <= nfpi_pkg::NFPI_CYC_ADDR;
              cyc.wdata <= (addr_idx == 2'h1)
                ? {8'h00, row[7:0]} : {8'h00, row[15:8]}; // RQ17
              addr_idx <= addr_idx + 2'h1;
              cyc.start <= 1'b1;
            end else if (op == nfpi_pkg::NFPI_OP_PROGRAM) begin
              state <= H_WDATA;
            end else if (op == nfpi_pkg::NFPI_OP_ERASE) begin
              cyc.kind <= nfpi_pkg::NFPI_CYC_CMD;
              cyc.wdata <= {8'h00, nfpi_pkg::CMD_ERASE_GO};
              cyc.start <= 1'b1;
              state <= H_CMD2;
            end else begin
              busy_wait <= 4'h0;
              state <= H_WAIT_BUSY; // RQ10
            end
          end
        end
        H_WDATA: begin
          if (pending) begin
            pending <= 1'b0;
            if (words == '0) begin
              cyc.kind <= nfpi_pkg::NFPI_CYC_CMD;
              cyc.wdata <= {8'h00, nfpi_pkg::CMD_PROG_GO};
              cyc.start <= 1'b1;
              state <= H_CMD2;
            end else begin
              cyc.kind <= nfpi_pkg::NFPI_CYC_WDATA; // RQ3
              cyc.wdata <= wr_data; // RQ1
              wr_take <= 1'b1;
              cyc.start <= 1'b1;
              words <= words - 10'h001;
            end
          end else if (cyc.done) begin
            pending <= 1'b1;
          end
        end
        H_CMD2: begin
          if (cyc.done) begin
            busy_wait <= 4'h0;
            state <= H_WAIT_BUSY;
          end
        end
        H_WAIT_BUSY: begin
          // allow a few cycles for the device to pull busy low
          busy_wait <= busy_wait + 4'h1;
          if (busy_q || busy_wait == nfpi_pkg::BUSY_WAIT_CNT) begin
            state <= H_WAIT_READY;
          end
        end
        H_WAIT_READY: begin
          // device times program and erase itself; host only watches
          if (!busy_q) begin // RQ13 RQ14 RQ16
            pending <= 1'b1;
            state <= (op == nfpi_pkg::NFPI_OP_READ) ? H_RDATA : H_END;
          end
        end
        H_RDATA: begin
          if (pending) begin
            pending <= 1'b0;
            if (words == '0) begin
              state <= H_END;
            end else begin
              cyc.kind <= nfpi_pkg::NFPI_CYC_RDATA; // RQ8
              cyc.start <= 1'b1;
              words <= words - 10'h001;
            end
          end else if (cyc.done) begin
            rd_data <= cyc.rdata; // RQ1
            rd_valid <= 1'b1;
            pending <= 1'b1;
          end
        end
        H_END: begin
          // deselect, but busy operations finish regardless
          chip_select_n <= 1'b1; // RQ7
          write_protect_n <= 1'b0;
          op_done <= 1'b1;
          state <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

// ### nfpi_host_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// pin protocol checks
// ------------------------------------------------------------
module nfpi_host_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] io_out,
  input wire logic io_oe,
  input wire logic io_oe_hi,
  input wire logic chip_select_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic ready_busy_n,
  input wire logic req_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence wr_held;
    !write_strobe_n && $past(!write_strobe_n);
  endsequence
  sequence rd_low;
    (!output_strobe_n)[*5];
  endsequence
  sequence rd_high;
    output_strobe_n[*5];
  endsequence
  cs_on_write_a: assert property (!write_strobe_n |-> !chip_select_n)
    else $error("write strobe without chip select");
  one_latch_a: assert property (!(cmd_latch && addr_latch))
    else $error("both latches high");
  latch_hold_a: assert property (wr_held |-> $stable(cmd_latch)
    && $stable(addr_latch)) else $error("latch moved in write strobe");
  bus_hold_a: assert property (wr_held |-> io_oe && $stable(io_out))
    else $error("bus moved in write strobe");
  rd_float_a: assert property (!output_strobe_n |-> !io_oe && !io_oe_hi
    && write_strobe_n) else $error("host drives during read");
  hi_byte_a: assert property ((cmd_latch || addr_latch)
    && !write_strobe_n |-> !io_oe_hi) else $error("upper byte on cmd");
  wr_width_a: assert property ($fell(write_strobe_n)
    |-> (!write_strobe_n)[*5]) else $error("write strobe too short");
  rd_cycle_a: assert property ($fell(output_strobe_n)
    |-> rd_low ##[1:3] rd_high) else $error("read cycle too short");
  busy_block_a: assert property ((!ready_busy_n)[*3] |-> !req_ready)
    else $error("ready while busy");
endmodule
bind nfpi_host nfpi_host_assertions chk (.clk, .reset, .io_out, .io_oe,
  .io_oe_hi, .chip_select_n, .cmd_latch, .addr_latch, .write_strobe_n,
  .output_strobe_n, .ready_busy_n, .req_ready);

// ### nfpi_flash_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// behavioural flash, one page; busy times shortened
// ------------------------------------------------------------
module nfpi_flash_model #(
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 4000,
  parameter int READ_NS = 300,
  parameter int VALID_NS = 30
) (
  input wire logic [15:0] host_io,
  input wire logic host_oe,
  input wire logic chip_select_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic write_protect_n,
  input wire logic spare_select_n,
  output logic [15:0] io_seen,
  output logic ready_busy_n
);
  logic [15:0] page [0:263];
  logic [15:0] buff [0:263];
  logic [15:0] dout = 16'hffff;
  logic [7:0] op = 8'hff;
  logic dev_oe = 1'b0;
  int col = 0;
  int base = 0;
  int nadr = 0;
  int blen = 0;
  event go;
  initial begin
    ready_busy_n = 1'b1;
    foreach (page[i]) page[i] = 16'hffff;
  end
  // released bus shows the inverse of the last word, never a held value
  assign io_seen = host_oe ? host_io : (dev_oe ? dout : ~dout);
  always @(go) begin
    ready_busy_n = 1'b0;
    #(blen);
    ready_busy_n = 1'b1;
  end
  always @(posedge write_strobe_n) if (!chip_select_n) begin
    if (cmd_latch) begin
      op = host_io[7:0];
      nadr = 0;
      base = (op == 8'h01) ? 128 : (op == 8'h50) ? 256 : 0;
      if (op == 8'h80) buff = page;
      if (op == 8'hff) begin blen = 100; ->go; end
      if (write_protect_n && op == 8'h10) begin
        page = buff;
        blen = PROG_NS;
        ->go;
      end
      if (write_protect_n && op == 8'hd0) begin
        foreach (page[i]) page[i] = 16'hffff;
        blen = ERASE_NS;
        ->go;
      end
    end else if (addr_latch) begin
      nadr++;
      if (nadr == 1 && op != 8'h60) col = base + host_io[7:0];
      if (nadr == 3 && op != 8'h80) begin blen = READ_NS; ->go; end
    end else if (col < 264) begin
      buff[col] = host_io;
      col++;
    end
  end
  always @(negedge output_strobe_n) if (!chip_select_n) begin
    #(VALID_NS);
    dout = (op == 8'h70) ? {8'h00, write_protect_n, ready_busy_n, 6'h00}
      : page[col];
    dev_oe = 1'b1;
    col++;
    if (col == 264 || (spare_select_n && col == 256)) col = 0;
  end
  always @(posedge output_strobe_n) dev_oe = 1'b0;
endmodule

// ### nand_flash_pin_interface_tb.sv
`timescale 1ns/1ps
module nand_flash_pin_interface_tb;
  logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, we = 1'b0, sp = 1'b1;
  nfpi_pkg::nfpi_op_e op = nfpi_pkg::NFPI_OP_STATUS;
  logic [7:0] col = 8'h00;
  logic [9:0] nw = 10'h001;
  logic [15:0] wr_data = 16'h1234, io_in, io_out, rd_data, pat, e0, e1;
  logic req_ready, wr_take, rd_valid, op_done, io_oe, io_oe_hi;
  logic chip_select_n, cmd_latch, addr_latch, write_strobe_n;
  logic output_strobe_n, write_protect_n, spare_select_n, ready_busy_n;
  logic wp_seen, uh = 1'b0;
  logic [15:0] rd_q [$];
  int bad_count = 0, checks = 0;
  always #2.5 clk = ~clk;
  nfpi_host dut (.clk(clk), .reset(reset), .clk_en(1'b1),
    .req_valid(req_valid), .req_op(op), .req_column(col),
    .req_row(16'h0123), .req_words(nw), .req_upper_half(uh),
    .req_include_spare(sp), .req_write_enable(we), .req_ready(req_ready),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .op_done(op_done), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .io_oe_hi(io_oe_hi),
    .chip_select_n(chip_select_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .write_protect_n(write_protect_n),
    .spare_select_n(spare_select_n), .ready_busy_n(ready_busy_n));
  nfpi_flash_model flash (.host_io(io_out), .host_oe(io_oe),
    .chip_select_n(chip_select_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .write_protect_n(write_protect_n),
    .spare_select_n(spare_select_n), .io_seen(io_in),
    .ready_busy_n(ready_busy_n));
  // ------------------------------------------------------------
  // stimulus helpers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (wr_take === 1'b1) wr_data <= wr_data + 16'h1357;
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (chip_select_n === 1'b0 && write_protect_n === 1'b1) wp_seen <= 1;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input nfpi_pkg::nfpi_op_e o, input logic [7:0] c,
    input logic [9:0] n, input logic w, input logic s);
    int k;
    k = 0;
    rd_q = {};
    wp_seen <= 1'b0;
    while (req_ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    op <= o;
    col <= c;
    nw <= n;
    we <= w;
    sp <= s;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    while (op_done !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
      if (chip_select_n === 1'b0) check(spare_select_n, !s);
    end
    check(k < 3000, 1'b1);
  endtask
  task automatic rd2(input logic [7:0] c, input logic s,
    input logic [15:0] a, input logic [15:0] b);
    run(nfpi_pkg::NFPI_OP_READ, c, 10'h002, 1'b0, s);
    check(rd_q.size() > 0 ? rd_q[0] : 16'hxxxx, a);
    check(rd_q.size() > 1 ? rd_q[1] : 16'hxxxx, b);
  endtask
  // writes two words, reads them back, then a protected rewrite is lost
  task automatic t_program;
    e0 = pat;
    e1 = pat + 16'h1357;
    run(nfpi_pkg::NFPI_OP_PROGRAM, 8'h03, 10'h002, 1'b1, 1'b1);
    check(wp_seen, 1'b1);
    rd2(8'h03, 1'b1, e0, e1);
    run(nfpi_pkg::NFPI_OP_PROGRAM, 8'h03, 10'h002, 1'b0, 1'b1);
    check(wp_seen, 1'b0);
    rd2(8'h03, 1'b1, e0, e1);
    pat = pat + 16'h4d5c;
  endtask
  // last main column then first spare column, or wrap when spare is off
  task automatic t_spare;
    e0 = pat;
    e1 = pat + 16'h1357;
    run(nfpi_pkg::NFPI_OP_PROGRAM, 8'hff, 10'h002, 1'b1, 1'b1);
    rd2(8'hff, 1'b1, e0, e1);
    // second-half read command, then a plain read starts in the first half
    uh <= 1'b1;
    rd2(8'h7f, 1'b1, e0, e1);
    uh <= 1'b0;
    rd2(8'hff, 1'b0, e0, 16'hffff);
    pat = pat + 16'h26ae;
  endtask
  task automatic t_erase;
    run(nfpi_pkg::NFPI_OP_ERASE, 8'h00, 10'h001, 1'b1, 1'b1);
    rd2(8'h03, 1'b1, 16'hffff, 16'hffff);
  endtask
  task automatic t_status;
    run(nfpi_pkg::NFPI_OP_STATUS, 8'h00, 10'h001, 1'b0, 1'b1);
    check(rd_q.size() > 0 ? rd_q[0] : 16'hxxxx, 16'h0040);
    run(nfpi_pkg::NFPI_OP_RESET, 8'h00, 10'h001, 1'b0, 1'b1);
    check(rd_q.size(), 16'h0000);
  endtask
  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #300us;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run;
  end
  initial begin
    pat = 16'h1234;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_program;
    t_spare;
    t_erase;
    t_status;
    complete_run;
  end
endmodule
